// >>> rtl/tpg_pkg.sv
// Constants for the test pattern generator: register map, selector codes, widths.
// Assumes a 32-bit classic Wishbone register bus and a 40 MHz system clock.
package tpg_pkg;
  localparam int unsigned PIX_W = 12;
  localparam int unsigned COORD_W = 12;
  localparam int unsigned CLK_HZ = 40000000;
  // Register byte offsets
  localparam logic [7:0] ADDR_SEL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CNT = 8'h0c;
  // Selector field
  localparam int unsigned SEL_W = 3;
  localparam logic [2:0] SEL_RESET = 3'h0;
  // Config field positions
  localparam int unsigned CFG_COLOR_BIT = 0;
  localparam int unsigned CFG_NARROW_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  // Status field positions
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_DIGITAL_BIT = 1;
  localparam int unsigned STAT_SEL_LSB = 4;
  localparam logic [PIX_W-1:0] CNT_RESET = 12'h000;
  localparam logic [PIX_W-1:0] MASK_8 = 12'h0ff;
  localparam logic [PIX_W-1:0] MASK_10 = 12'h3ff;
  localparam logic [PIX_W-1:0] MASK_12 = 12'hfff;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  typedef enum logic [2:0] {
    PAT_OFF = 3'b000,
    PAT_FIXED8 = 3'b001,
    PAT_MOVE8 = 3'b010,
    PAT_MOVE12 = 3'b011,
    PAT_FEAT8 = 3'b100,
    PAT_FEAT12 = 3'b101,
    PAT_COLOR = 3'b110
  } pattern_type;
endpackage : tpg_pkg

// >>> rtl/tpg_regs.sv
// Wishbone classic slave holding pattern selector and variant configuration.
// Assumes a classic single-cycle master; answers one cycle after the request.
`timescale 1ns/10ps
module tpg_regs
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [31:0] stat_i,
  input wire logic [11:0] cnt_i,
  output logic [2:0] sel_o,
  output logic [1:0] cfg_o
);
  logic req;
  logic [2:0] sel_r;
  logic [1:0] cfg_r;
  logic [31:0] rd_nxt;

  assign sel_o = sel_r;
  assign cfg_o = cfg_r;
  assign req = cyc_i && stb_i && !ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  // Only off or one of six patterns is stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sel_r <= tpg_pkg::SEL_RESET;
    else if (req && we_i && sel_i[0] && adr_i == tpg_pkg::ADDR_SEL && dat_i[2:0] != 3'h7)
      sel_r <= dat_i[2:0]; // see R1
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_r <= tpg_pkg::CFG_RESET;
    else if (req && we_i && sel_i[0] && adr_i == tpg_pkg::ADDR_CFG)
      cfg_r <= dat_i[1:0];
  end

  always_comb
  begin
    case (adr_i)
      tpg_pkg::ADDR_SEL: rd_nxt = {29'h0, sel_r};
      tpg_pkg::ADDR_CFG: rd_nxt = {30'h0, cfg_r};
      tpg_pkg::ADDR_STAT: rd_nxt = stat_i;
      tpg_pkg::ADDR_CNT: rd_nxt = {20'h0, cnt_i};
      default: rd_nxt = tpg_pkg::UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0;
    else if (req && !we_i)
      dat_o <= rd_nxt;
  end
endmodule : tpg_regs

// >>> rtl/tpg_calc.sv
// Gradient arithmetic: column plus row plus optional counter, masked to width.
// Assumes coordinates counted from zero by the caller.
`timescale 1ns/10ps
module tpg_calc
(
  input wire logic [11:0] col_i,
  input wire logic [11:0] row_i,
  input wire logic [11:0] cnt_i,
  input wire logic moving_i,
  input wire logic [11:0] mask_i,
  output logic [11:0] value_o
);
  logic [11:0] sum;

  always_comb
  begin
    sum = col_i + row_i + (moving_i ? cnt_i : 12'h000);
    value_o = sum & mask_i;
  end
endmodule : tpg_calc

// >>> rtl/test_pattern_generator.sv
// Test pattern generator: replaces sensor pixels with computed gradients.
// Assumes sensor and processed pixels arrive on clk_i, one per cycle with valid.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
// Operation
// R1 - Selector holds off or one of six
// R2 - Pattern pixels computed, sensor data ignored
// R3 - Analog settings cannot alter pattern pixels
// R4 - Patterns 1,2,3,6 bypass digital processing
// R5 - Patterns 4,5 go through digital processing
// R6 - Pattern 1: column plus row mod 256
// R7 - Pattern 2: adds counter, mod 256
// R8 - Counter increments once per acquisition start
// R9 - Moving patterns shift one pixel per acquisition
// R10 - Pattern 3: adds counter, mod 4096
// R11 - Narrow variant makes patterns 3,5 ten-bit
// R12 - Pattern 4 values equal pattern 2
// R13 - Pattern 5 values equal pattern 3
// R14 - Pattern 6 only on colour variants
// R15 - Host converts colour YUV to RGB
// R16 - Counter wraps, resets zero, coordinates from zero
module test_pattern_generator
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic acq_start_i,
  input wire logic sensor_valid_i,
  input wire logic sensor_sof_i,
  input wire logic sensor_eol_i,
  input wire logic [11:0] sensor_data_i,
  output logic proc_valid_o,
  output logic proc_sof_o,
  output logic [11:0] proc_data_o,
  input wire logic proc_ret_valid_i,
  input wire logic proc_ret_sof_i,
  input wire logic [11:0] proc_ret_data_i,
  output logic tx_valid_o,
  output logic tx_sof_o,
  output logic [11:0] tx_data_o,
  output logic [11:0] tx_chroma_o
);
  logic [2:0] sel_r;
  logic [1:0] cfg_r;
  logic [11:0] cnt_r;
  logic [11:0] col_r;
  logic [11:0] row_r;
  logic [11:0] col_now;
  logic [11:0] row_now;
  logic [11:0] grad;
  logic [11:0] mask;
  logic moving;
  logic active;
  logic digital;
  logic [31:0] stat;
  tpg_pkg::pattern_type pat;

  // Pattern decode shared by routing and status
  function automatic logic through_digital(input tpg_pkg::pattern_type p);
    through_digital = (p == tpg_pkg::PAT_FEAT8) || (p == tpg_pkg::PAT_FEAT12);
  endfunction : through_digital

  // Colour pattern falls back to off on mono variants
  always_comb
  begin
    case (sel_r)
      3'b000: pat = tpg_pkg::PAT_OFF;
      3'b001: pat = tpg_pkg::PAT_FIXED8;
      3'b010: pat = tpg_pkg::PAT_MOVE8;
      3'b011: pat = tpg_pkg::PAT_MOVE12;
      3'b100: pat = tpg_pkg::PAT_FEAT8;
      3'b101: pat = tpg_pkg::PAT_FEAT12;
      3'b110: pat = cfg_r[tpg_pkg::CFG_COLOR_BIT] ? tpg_pkg::PAT_COLOR
                                                  : tpg_pkg::PAT_OFF; // see R14
      default: pat = tpg_pkg::PAT_OFF;
    endcase
  end

  assign active = (pat != tpg_pkg::PAT_OFF);
  assign digital = through_digital(pat);
  assign stat = {25'h0, sel_r, 2'h0, digital, active};

  tpg_regs u_regs
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .stat_i(stat),
    .cnt_i(cnt_r),
    .sel_o(sel_r),
    .cfg_o(cfg_r)
  );

  // Acquisition counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_r <= tpg_pkg::CNT_RESET; // see R16
    else if (acq_start_i)
      cnt_r <= cnt_r + 12'h001; // see R8
  end

  // Coordinates of the current pixel
  always_comb
  begin
    col_now = sensor_sof_i ? 12'h000 : col_r; // see R16
    row_now = sensor_sof_i ? 12'h000 : row_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      col_r <= 12'h000;
      row_r <= 12'h000;
    end
    else if (sensor_valid_i)
    begin
      if (sensor_eol_i)
      begin
        col_r <= 12'h000;
        row_r <= row_now + 12'h001;
      end
      else
      begin
        col_r <= col_now + 12'h001;
        row_r <= row_now;
      end
    end
  end

  // Width and motion per pattern
  always_comb
  begin
    moving = 1'b1; // see R9
    case (pat)
      tpg_pkg::PAT_FIXED8:
      begin
        moving = 1'b0;
        mask = tpg_pkg::MASK_8; // see R6
      end
      tpg_pkg::PAT_MOVE8: mask = tpg_pkg::MASK_8; // see R7
      tpg_pkg::PAT_FEAT8: mask = tpg_pkg::MASK_8; // see R12
      tpg_pkg::PAT_MOVE12, tpg_pkg::PAT_FEAT12:
        mask = cfg_r[tpg_pkg::CFG_NARROW_BIT] ? tpg_pkg::MASK_10
                                              : tpg_pkg::MASK_12; // see R10 see R11 see R13
      tpg_pkg::PAT_COLOR: mask = tpg_pkg::MASK_8;
      default: mask = tpg_pkg::MASK_12;
    endcase
  end

  tpg_calc u_calc
  (
    .col_i(col_now),
    .row_i(row_now),
    .cnt_i(cnt_r),
    .moving_i(moving),
    .mask_i(mask),
    .value_o(grad)
  );

  // Feed into digital processing: sensor, or pattern for 4 and 5
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      proc_valid_o <= 1'b0;
      proc_sof_o <= 1'b0;
      proc_data_o <= 12'h000;
    end
    else
    begin
      proc_valid_o <= sensor_valid_i && (!active || digital);
      proc_sof_o <= sensor_sof_i && sensor_valid_i && (!active || digital);
      proc_data_o <= digital ? grad : (active ? 12'h000 : sensor_data_i); // see R2 see R3 see R5
    end
  end

  // Transmit: processed return path, or direct pattern for 1,2,3,6
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_valid_o <= 1'b0;
      tx_sof_o <= 1'b0;
      tx_data_o <= 12'h000;
      tx_chroma_o <= 12'h000;
    end
    else if (active && !digital)
    begin
      tx_valid_o <= sensor_valid_i; // see R4
      tx_sof_o <= sensor_sof_i && sensor_valid_i;
      tx_data_o <= grad; // see R2 see R3
      tx_chroma_o <= (pat == tpg_pkg::PAT_COLOR) ? (tpg_pkg::MASK_8 - grad) : 12'h000;
    end
    else
    begin
      tx_valid_o <= proc_ret_valid_i; // see R5
      tx_sof_o <= proc_ret_sof_i && proc_ret_valid_i;
      tx_data_o <= proc_ret_data_i;
      tx_chroma_o <= 12'h000;
    end
  end

  // Selector, counter and coordinates
  a_sel_legal: assert property (@(posedge clk_i) disable iff (rst_i) // see R1
    sel_r != 3'h7) else $error("selector holds illegal value");
  a_cnt_reset: assert property (@(posedge clk_i) // see R16
    rst_i |=> cnt_r == tpg_pkg::CNT_RESET) else $error("counter not cleared by reset");
  a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i) // see R8
    acq_start_i |=> cnt_r == $past(cnt_r) + 12'h001) else $error("counter step wrong");
  a_cnt_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see R8
    !acq_start_i |=> $stable(cnt_r)) else $error("counter moved without start");
  a_col_step: assert property (@(posedge clk_i) disable iff (rst_i) // see R16
    (sensor_valid_i && !sensor_eol_i) |=>
      col_r == $past(col_now) + 12'h001 && row_r == $past(row_now))
    else $error("column step wrong");
  a_row_step: assert property (@(posedge clk_i) disable iff (rst_i) // see R16
    (sensor_valid_i && sensor_eol_i) |=>
      col_r == 12'h000 && row_r == $past(row_now) + 12'h001)
    else $error("row step wrong");

  // Pattern values
  a_fixed_value: assert property (@(posedge clk_i) disable iff (rst_i) // see R6
    (pat == tpg_pkg::PAT_FIXED8 && sensor_valid_i) |=>
      tx_data_o == (($past(col_now) + $past(row_now)) & tpg_pkg::MASK_8))
    else $error("fixed gradient wrong");
  a_move8_value: assert property (@(posedge clk_i) disable iff (rst_i) // see R7
    (pat == tpg_pkg::PAT_MOVE8 && sensor_valid_i) |=>
      tx_data_o == (($past(col_now) + $past(row_now) + $past(cnt_r)) & tpg_pkg::MASK_8))
    else $error("moving 8-bit gradient wrong");
  a_move12_value: assert property (@(posedge clk_i) disable iff (rst_i) // see R10
    (pat == tpg_pkg::PAT_MOVE12 && !cfg_r[tpg_pkg::CFG_NARROW_BIT] && sensor_valid_i) |=>
      tx_data_o == $past(col_now) + $past(row_now) + $past(cnt_r))
    else $error("moving 12-bit gradient wrong");
  a_narrow_move: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
    (pat == tpg_pkg::PAT_MOVE12 && cfg_r[tpg_pkg::CFG_NARROW_BIT]) |=>
      tx_data_o[11:10] == 2'b00)
    else $error("narrow moving pattern exceeds ten bits");
  a_narrow_bits: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
    (pat == tpg_pkg::PAT_FEAT12 && cfg_r[tpg_pkg::CFG_NARROW_BIT]) |=>
      proc_data_o[11:10] == 2'b00)
    else $error("narrow variant exceeds ten bits");
  a_feat8_value: assert property (@(posedge clk_i) disable iff (rst_i) // see R12
    (pat == tpg_pkg::PAT_FEAT8 && sensor_valid_i) |=>
      proc_data_o == (($past(col_now) + $past(row_now) + $past(cnt_r)) & tpg_pkg::MASK_8))
    else $error("feature 8-bit gradient wrong");
  a_feat12_value: assert property (@(posedge clk_i) disable iff (rst_i) // see R13
    (pat == tpg_pkg::PAT_FEAT12 && !cfg_r[tpg_pkg::CFG_NARROW_BIT] && sensor_valid_i) |=>
      proc_data_o == $past(col_now) + $past(row_now) + $past(cnt_r))
    else $error("feature 12-bit gradient wrong");

  // Routing
  a_feat_route: assert property (@(posedge clk_i) disable iff (rst_i) // see R5
    (digital && sensor_valid_i) |=> proc_valid_o && proc_data_o == $past(grad))
    else $error("feature pattern not sent to processing");
  a_feat_return: assert property (@(posedge clk_i) disable iff (rst_i) // see R5
    (active && digital) |=>
      tx_valid_o == $past(proc_ret_valid_i) && tx_data_o == $past(proc_ret_data_i))
    else $error("processed pixel not transmitted");
  a_off_pass: assert property (@(posedge clk_i) disable iff (rst_i) // see R1
    (!active && sensor_valid_i) |=> proc_valid_o && proc_data_o == $past(sensor_data_i))
    else $error("sensor pixel not passed when off");
  a_sof_feed: assert property (@(posedge clk_i) disable iff (rst_i) // see R16
    (sensor_valid_i && (!active || digital)) |=> proc_sof_o == $past(sensor_sof_i))
    else $error("frame start lost towards processing");
  a_bypass_route: assert property (@(posedge clk_i) disable iff (rst_i) // see R4
    (active && !digital) |=> !proc_valid_o) else $error("bypass pattern reached processing");
  a_bypass_valid: assert property (@(posedge clk_i) disable iff (rst_i) // see R4
    (active && !digital) |=> tx_valid_o == $past(sensor_valid_i))
    else $error("bypass pattern lost valid");
  a_sof_direct: assert property (@(posedge clk_i) disable iff (rst_i) // see R16
    (active && !digital && sensor_valid_i) |=> tx_sof_o == $past(sensor_sof_i))
    else $error("frame start lost on bypass");
  a_no_sensor: assert property (@(posedge clk_i) disable iff (rst_i) // see R2
    (active && !digital && sensor_valid_i) |=> tx_data_o == $past(grad))
    else $error("sensor data leaked into pattern");
  a_color_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see R14
    (sel_r == 3'h6 && !cfg_r[tpg_pkg::CFG_COLOR_BIT]) |-> !active) else $error("colour on mono");
  a_color_value: assert property (@(posedge clk_i) disable iff (rst_i) // see R14
    (pat == tpg_pkg::PAT_COLOR && sensor_valid_i) |=>
      tx_data_o == (($past(col_now) + $past(row_now) + $past(cnt_r)) & tpg_pkg::MASK_8) &&
      tx_chroma_o == tpg_pkg::MASK_8 - tx_data_o)
    else $error("colour gradient wrong");
  a_chroma_idle: assert property (@(posedge clk_i) disable iff (rst_i) // see R14
    (pat != tpg_pkg::PAT_COLOR) |=> tx_chroma_o == 12'h000)
    else $error("chroma set outside colour pattern");

  c_fixed: cover property (@(posedge clk_i) pat == tpg_pkg::PAT_FIXED8 && sensor_valid_i);
  c_move_acq: cover property (@(posedge clk_i) pat == tpg_pkg::PAT_MOVE8 && acq_start_i);
  c_feat12: cover property (@(posedge clk_i) pat == tpg_pkg::PAT_FEAT12 && sensor_valid_i);
  c_narrow: cover property (@(posedge clk_i)
    pat == tpg_pkg::PAT_FEAT12 && cfg_r[tpg_pkg::CFG_NARROW_BIT] && sensor_valid_i);
  c_color: cover property (@(posedge clk_i) pat == tpg_pkg::PAT_COLOR && sensor_valid_i);
endmodule : test_pattern_generator

// >>> dv/proc_path_model.sv
// Digital processing path model: inverting lookup table, one or two cycles deep.
// Assumes pixels arrive with valid on clk_i; slow_i picks the deeper path.
`timescale 1ns/10ps
module proc_path_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic sof_i,
  input wire logic [11:0] data_i,
  output logic ret_valid_o,
  output logic ret_sof_o,
  output logic [11:0] ret_data_o
);
  logic [13:0] s1_r;
  logic [13:0] s2_r;
  logic [13:0] o_r;
  always_ff @(posedge clk_i)
  begin
    s1_r <= rst_i ? 14'h0000 : {valid_i, sof_i, ~data_i};
    s2_r <= s1_r;
  end
  always_comb o_r = slow_i ? s2_r : s1_r;
  assign ret_valid_o = o_r[13];
  assign ret_sof_o = o_r[12] & o_r[13];
  // Idle data repeats the input of two cycles back, uninverted
  assign ret_data_o = o_r[13] ? o_r[11:0] : ~s2_r[11:0];
endmodule : proc_path_model

// >>> dv/tb_test_pattern_generator.sv
// Self-checking bench for the test pattern generator.
// Assumes the processing path model answers with an inverting lookup table.
`timescale 1ns/10ps
module tb_test_pattern_generator;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, acq_start_i = 0, slow = 0;
  logic sensor_valid_i = 0, sensor_sof_i = 0, sensor_eol_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000, dat_o, q;
  logic [11:0] sensor_data_i = 12'h000, proc_data_o, proc_ret_data_i, tx_data_o, tx_chroma_o;
  logic ack_o, proc_valid_o, proc_sof_o, proc_ret_valid_i, proc_ret_sof_i;
  logic tx_valid_o, tx_sof_o;
  logic [11:0] cnt_exp = 12'h000;
  logic [31:0] rs = 32'd63117;
  logic [13:0] expq[$];
  logic [13:0] e;
  int miscompares = 0, n_tests = 0, proc_cnt = 0;
  always #12.5 clk_i = ~clk_i;
  test_pattern_generator test_pattern_generator_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .acq_start_i(acq_start_i), .sensor_valid_i(sensor_valid_i),
    .sensor_sof_i(sensor_sof_i), .sensor_eol_i(sensor_eol_i), .sensor_data_i(sensor_data_i),
    .proc_valid_o(proc_valid_o), .proc_sof_o(proc_sof_o), .proc_data_o(proc_data_o),
    .proc_ret_valid_i(proc_ret_valid_i), .proc_ret_sof_i(proc_ret_sof_i),
    .proc_ret_data_i(proc_ret_data_i), .tx_valid_o(tx_valid_o), .tx_sof_o(tx_sof_o),
    .tx_data_o(tx_data_o), .tx_chroma_o(tx_chroma_o));
  proc_path_model proc_path_model_i (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .valid_i(proc_valid_o), .sof_i(proc_sof_o), .data_i(proc_data_o),
    .ret_valid_o(proc_ret_valid_i), .ret_sof_o(proc_ret_sof_i), .ret_data_o(proc_ret_data_i));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  // Expected transmit word: {chroma check, sof, data}
  function automatic logic [13:0] exp_pix(input logic [2:0] p, input logic [1:0] c,
    input logic [11:0] x, input logic [11:0] y, input logic [11:0] sd);
    logic [11:0] g;
    logic [11:0] m;
    g = x + y + ((p == 3'h1) ? 12'h000 : cnt_exp);
    m = (p == 3'h3 || p == 3'h5) ? (c[1] ? 12'h3ff : 12'hfff) : 12'h0ff;
    if (p >= 3'h1 && p <= 3'h3) return {2'b00, g & m};
    if (p == 3'h4 || p == 3'h5) return {2'b00, ~(g & m)};
    if (p == 3'h6 && c[0]) return {2'b10, g & 12'h0ff};
    return {2'b00, ~sd};
  endfunction : exp_pix
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    q = dat_o;
    chk(n < 50, "bus answer missing");
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic acq();
    acq_start_i <= 1;
    @(posedge clk_i);
    acq_start_i <= 0;
    cnt_exp++;
    @(posedge clk_i);
  endtask : acq
  task automatic frame(input logic [2:0] p, input logic [1:0] c);
    logic [11:0] sd;
    int np;
    wb(1, 8'h04, {30'h0, c});
    wb(1, 8'h00, {29'h0, p});
    wb(0, 8'h08, 32'h0);
    chk(q[6:4] === p && q[1] === (p == 3'h4 || p == 3'h5), "status");
    chk(q[0] === (p != 3'h0 && !(p == 3'h6 && !c[0])), "active flag");
    slow <= rnd() & 1;
    acq();
    np = proc_cnt;
    for (int y = 0; y < 3; y++)
      for (int x = 0; x < 4; x++)
      begin
        sd = rnd() & 12'hfff;
        sensor_valid_i <= 1;
        sensor_sof_i <= (x == 0 && y == 0);
        sensor_eol_i <= (x == 3);
        sensor_data_i <= sd;
        expq.push_back(exp_pix(p, c, x, y, sd) | ((x == 0 && y == 0) << 12));
        @(posedge clk_i);
      end
    sensor_valid_i <= 0;
    repeat (8) @(posedge clk_i);
    chk(expq.size() == 0, "pixels missing");
    chk((proc_cnt - np) == (((p >= 3'h1 && p <= 3'h3) || (p == 3'h6 && c[0])) ? 0 : 12),
      "processing route");
    $display("frame sel %0d cfg %0d done", p, c);
  endtask : frame
  always @(posedge clk_i)
  begin
    if (proc_valid_o === 1'b1) proc_cnt++;
    if (tx_valid_o === 1'b1)
    begin
      if (expq.size() == 0)
        chk(0, "unexpected pixel");
      else
      begin
        e = expq.pop_front();
        chk(tx_sof_o === e[12], "frame start");
        chk(tx_data_o === e[11:0], "pixel value");
        if (e[13])
          chk(tx_chroma_o === 12'h0ff - e[11:0], "colour pixel");
        else
          chk(tx_chroma_o === 12'h000, "chroma idle");
      end
    end
  end
  initial
  begin
    #(25 * 40000);
    miscompares++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (int a = 0; a < 20; a += 4)
    begin
      wb(0, a[7:0], 32'h0);
      chk(q === 32'h0, "reset value");
    end
    wb(1, 8'h00, 32'h2);
    wb(1, 8'h00, 32'h7);
    wb(0, 8'h00, 32'h0);
    chk(q[2:0] === 3'h2, "selector refusal");
    for (int c = 0; c < 4; c++)
      for (int p = 0; p < 7; p++)
        frame(p[2:0], c[1:0]);
    repeat (10) frame(rnd() % 7, rnd() & 3);
    for (int i = 0; i < 4096; i++) acq();
    wb(0, 8'h0c, 32'h0);
    chk(q[11:0] === cnt_exp, "counter wrap");
    frame(3'h5, 2'h2);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    cnt_exp = 12'h000;
    @(posedge clk_i);
    wb(0, 8'h0c, 32'h0);
    chk(q === 32'h0, "counter after reset");
    frame(3'h3, 2'h0);
    $display("sequence done");
    complete_run();
  end
endmodule : tb_test_pattern_generator
